// >>> rscl_top.sv
// Summary of operation
// RQ1: sample straps when power-up or soft reset ends
// RQ2: relatch on power-down exit and reset release
// RQ3: start strap 0 holds forwarding until start bit
// RQ4: management strap 0 enables frame-based management
// RQ5: role strap picks PHY/clock-out or MAC/clock-in
// RQ6: speed strap 0 gigabit, 1 ten/hundred
// RQ7: interface strap: MII, RMII, reserved, RGMII
// RQ8: management select: MDIO, I2C, SPI if high
// RQ9: interrupt pin pulls low, otherwise released
// RQ10: wake output asserts on energy detect
// RQ11: wake polarity programmable, default active low
// RQ12: system drives reset low at power-on
// RQ13: general pins synchronised, capture or trigger
// RQ14: host drives or reads general pins by registers
// RQ15: indicator pins drive low to light
// RQ16: PHY strap picks autoneg or forced modes
// RQ17: receive-valid strap 1 selects test mode
// RQ18: hold latched straps, then release shared pins
// RQ19: reserved codes flagged, never undefined mode
//
// The Wishbone register port and the placing of the registers were chosen for this implementation.
module rscl_top
   import rscl_pkg::*;
#(
   parameter int SETTLE = SETTLE_CYC
) (
   input  wire logic              core_clk,
   input  wire logic              resetn,
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [ADR_W-1:0]  wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   output logic      [31:0]       wb_dat_o,
   output logic                   wb_ack_o,
   input  wire logic              port1_indicator_a_i,
   output logic                   port1_indicator_a_o,
   output logic                   port1_indicator_a_oe,
   input  wire logic              port1_indicator_b_i,
   output logic                   port1_indicator_b_o,
   output logic                   port1_indicator_b_oe,
   input  wire logic              port2_indicator_a_i,
   output logic                   port2_indicator_a_o,
   output logic                   port2_indicator_a_oe,
   input  wire logic              port2_indicator_b_i,
   output logic                   port2_indicator_b_o,
   output logic                   port2_indicator_b_oe,
   input  wire logic              port3_rx_bit3,
   input  wire logic              port3_rx_bit2,
   input  wire logic              port3_rx_bit1,
   input  wire logic              port3_rx_bit0,
   input  wire logic              port3_rx_error,
   input  wire logic              port3_rx_valid,
   input  wire logic              wake_event_out_i,
   output logic                   wake_event_out_o,
   output logic                   wake_event_out_oe,
   output logic                   irq_out_low_o,
   output logic                   irq_out_low_oe,
   input  wire logic [1:0]        gpio_pin_i,
   output logic      [1:0]        gpio_pin_o,
   output logic      [1:0]        gpio_pin_oe,
   input  wire logic [3:0]        led_on,
   input  wire logic              irq_req,
   input  wire logic              energy_detect,
   input  wire logic              pd_exit,
   input  wire logic [1:0]        ptp_trigger,
   output logic      [1:0]        ts_capture,
   output rscl_cfg_t              cfg_o,
   output logic                   strap_busy
);
   if (SETTLE < 1 || SETTLE > 255) begin : g_bad_settle
      $error("rscl_top: SETTLE must be 1..255");
   end

   localparam logic [7:0] LAST = 8'(SETTLE - 1);

   rscl_state_t state_q;
   logic [7:0]  cnt_q;
   rscl_strap_t strap_q;
   logic        start_q;
   logic        wake_hi_q;
   logic        swrst_q;
   logic [5:0]  gctl_q;
   logic [1:0]  gs1_q, gs2_q, gs3_q;
   logic        drive_q;
   logic        drive_d;
   logic        latch;
   logic        restart;
   logic        acc;
   rscl_strap_t pins;

   // ----------------------------------------------------------------
   // strap sampling sequence
   // ----------------------------------------------------------------
   assign pins    = {port3_rx_valid, port3_rx_error, wake_event_out_i,
                     port3_rx_bit1, port3_rx_bit0, port3_rx_bit3, port3_rx_bit2,
                     port2_indicator_b_i, port2_indicator_a_i,
                     port1_indicator_b_i, port1_indicator_a_i};
   assign latch   = (state_q == ST_SAMPLE) && (cnt_q == LAST);
   assign restart = (state_q == ST_RUN) && (swrst_q || pd_exit);
   // pins let go on the edge that reopens sampling, so the whole window settles
   assign drive_d = latch || ((state_q == ST_RUN) && !restart);

   // reset release, soft reset and power-down exit all reopen sampling
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= ST_SAMPLE;                         // [RQ2] [RQ12]
         cnt_q   <= 8'h00;
      end else begin
         unique case (state_q)
            ST_SAMPLE: begin
               cnt_q <= cnt_q + 8'h01;
               if (latch) begin
                  state_q <= ST_RUN;                   // [RQ1]
               end
            end
            ST_RUN: begin
               cnt_q <= 8'h00;
               if (restart) begin
                  state_q <= ST_SAMPLE;                // [RQ2]
               end
            end
            default: begin
               state_q <= ST_SAMPLE;
               cnt_q   <= 8'h00;
            end
         endcase
      end
   end

   // straps change only at the end of a sampling window
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         strap_q <= STRAP_RST;
      end else if (latch) begin
         strap_q <= pins;                              // [RQ1] [RQ18]
      end
   end

   // shared pins stay released while the board pulls set their level
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         drive_q    <= 1'b0;
         strap_busy <= 1'b1;
      end else begin
         drive_q    <= drive_d;                        // [RQ18]
         strap_busy <= !drive_d;
      end
   end

   // ----------------------------------------------------------------
   // decode of latched straps
   // ----------------------------------------------------------------
   // reserved codes fall back to the default mode and raise a flag
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cfg_o <= '0;
      end else begin
         cfg_o.fwd_en                    <= strap_q.start_sw || start_q;  // [RQ3]
         cfg_o.frame_based_management_en <= !strap_q.iba_n;               // [RQ4]
         cfg_o.p3_mac_mode               <= strap_q.p3_role;              // [RQ5]
         cfg_o.p3_refclk_out             <= !strap_q.p3_role &&
                                            (strap_q.p3_if == P3_RMII);   // [RQ5]
         cfg_o.p3_gig                    <= !strap_q.p3_speed;            // [RQ6]
         cfg_o.p3_if_bad                 <= strap_q.p3_if == P3_RSVD;     // [RQ19]
         cfg_o.p3_if                     <= (strap_q.p3_if == P3_RSVD) ? P3_MII
                                            : rscl_if_t'(strap_q.p3_if);  // [RQ7]
         cfg_o.mgmt_sel                  <= strap_q.mgmt[1] ? MG_SPI
                                            : rscl_mgmt_t'(strap_q.mgmt); // [RQ8]
         cfg_o.phy_bad                   <= strap_q.phy_cfg == PHY_RSVD;  // [RQ19]
         cfg_o.phy_mode                  <= (strap_q.phy_cfg == PHY_RSVD) ? PHY_AN_EEE
                                            : rscl_phy_t'(strap_q.phy_cfg); // [RQ16]
         cfg_o.test_mode                 <= strap_q.test_mode;            // [RQ17]
      end
   end

   // ----------------------------------------------------------------
   // wishbone slave, one wait state, unmapped reads return zero
   // ----------------------------------------------------------------
   assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= acc;
         if (acc && !wb_we_i) begin
            unique case (wb_adr_i)
               REG_CTRL:      wb_dat_o <= {29'h0, 1'b0, wake_hi_q, start_q};
               REG_STRAP:     wb_dat_o <= {20'h0, strap_busy, strap_q};
               REG_GPIO_CTRL: wb_dat_o <= {26'h0, gctl_q};
               REG_GPIO_STAT: wb_dat_o <= {30'h0, gs2_q};           // [RQ14]
               default:       wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // control writes; soft reset is a one-cycle self-clearing strobe
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         start_q   <= 1'b0;
         wake_hi_q <= 1'b0;                            // [RQ11]
         swrst_q   <= 1'b0;
         gctl_q    <= 6'h00;
      end else begin
         swrst_q <= 1'b0;
         if (acc && wb_we_i && wb_sel_i[0]) begin
            if (wb_adr_i == REG_CTRL) begin
               start_q   <= wb_dat_i[CTRL_START_BIT];  // [RQ3]
               wake_hi_q <= wb_dat_i[CTRL_WAKE_HI];    // [RQ11]
               swrst_q   <= wb_dat_i[CTRL_SWRST_BIT];  // [RQ1]
            end
            if (wb_adr_i == REG_GPIO_CTRL) begin
               gctl_q <= wb_dat_i[5:0];                // [RQ14]
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // status and indicator pins
   // ----------------------------------------------------------------
   // the level pins only drive once strap sampling is over
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         port1_indicator_a_o  <= 1'b1;
         port1_indicator_b_o  <= 1'b1;
         port2_indicator_a_o  <= 1'b1;
         port2_indicator_b_o  <= 1'b1;
         port1_indicator_a_oe <= 1'b0;
         port1_indicator_b_oe <= 1'b0;
         port2_indicator_a_oe <= 1'b0;
         port2_indicator_b_oe <= 1'b0;
         wake_event_out_o     <= 1'b1;
         wake_event_out_oe    <= 1'b0;
      end else begin
         port1_indicator_a_o  <= !led_on[0];           // [RQ15]
         port1_indicator_b_o  <= !led_on[1];
         port2_indicator_a_o  <= !led_on[2];
         port2_indicator_b_o  <= !led_on[3];
         port1_indicator_a_oe <= drive_d;              // [RQ18]
         port1_indicator_b_oe <= drive_d;
         port2_indicator_a_oe <= drive_d;
         port2_indicator_b_oe <= drive_d;
         wake_event_out_o     <= wake_hi_q ? energy_detect : !energy_detect; // [RQ10] [RQ11]
         wake_event_out_oe    <= drive_d;
      end
   end

   // open drain: data is always low, only the enable moves
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         irq_out_low_o  <= 1'b0;
         irq_out_low_oe <= 1'b0;
      end else begin
         irq_out_low_o  <= 1'b0;
         irq_out_low_oe <= irq_req;                    // [RQ9]
      end
   end

   // ----------------------------------------------------------------
   // general pins, sampled into the core_clk domain
   // ----------------------------------------------------------------
   // gs1 feeds only gs2; edges are taken between gs2 and gs3
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         // pins idle high on their pull-ups; a zero here would fake an edge
         gs1_q       <= 2'h3;
         gs2_q       <= 2'h3;
         gs3_q       <= 2'h3;
         ts_capture  <= 2'b00;
         gpio_pin_o  <= 2'b00;
         gpio_pin_oe <= 2'b00;
      end else begin
         gs1_q       <= gpio_pin_i;                    // [RQ13]
         gs2_q       <= gs1_q;
         gs3_q       <= gs2_q;
         ts_capture  <= ~gctl_q[GPIO_DIR_LSB +: 2] & gs2_q & ~gs3_q; // [RQ13]
         for (int i = 0; i < 2; i++) begin
            gpio_pin_o[i] <= gctl_q[GPIO_TRIG_LSB + i] ? ptp_trigger[i]
                             : gctl_q[GPIO_OUT_LSB + i];             // [RQ13] [RQ14]
         end
         gpio_pin_oe <= gctl_q[GPIO_DIR_LSB +: 2];     // [RQ14]
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   settle_run_a: assert property (latch |=> state_q == ST_RUN and drive_q) // [RQ1]
      else $error("sampling did not end in run");
   relatch_a: assert property (pd_exit && state_q == ST_RUN |=> // [RQ2]
                               state_q == ST_SAMPLE && !port1_indicator_a_oe)
      else $error("power-down exit did not reopen sampling");
   strap_hold_a: assert property (!latch |=> $stable(strap_q)) // [RQ18]
      else $error("straps moved outside a latch");
   fwd_gate_a: assert property (!strap_q.start_sw && !start_q |=> !cfg_o.fwd_en) // [RQ3]
      else $error("forwarding without start");
   mgmt_frame_a: assert property (1 |=> // [RQ4]
                                  cfg_o.frame_based_management_en == !$past(strap_q.iba_n))
      else $error("frame management decode wrong");
   clk_dir_a: assert property (strap_q.p3_role |=> !cfg_o.p3_refclk_out && cfg_o.p3_mac_mode) // [RQ5]
      else $error("mac role drives reference clock");
   spi_sel_a: assert property (strap_q.mgmt[1] |=> cfg_o.mgmt_sel == MG_SPI) // [RQ8]
      else $error("spi not selected");
   if_rsvd_a: assert property (strap_q.p3_if == P3_RSVD |=> // [RQ19] [RQ7]
                               cfg_o.p3_if_bad && cfg_o.p3_if == P3_MII)
      else $error("reserved interface code leaked");
   irq_pull_a: assert property (irq_req |=> irq_out_low_oe && !irq_out_low_o) // [RQ9]
      else $error("interrupt not pulled low");
   wake_pol_a: assert property (energy_detect && !wake_hi_q |=> !wake_event_out_o) // [RQ10]
      else $error("wake not asserted low");
   gpio_out_a: assert property (gctl_q[GPIO_DIR_LSB] && !gctl_q[GPIO_TRIG_LSB] |=> // [RQ14]
                                gpio_pin_oe[0] && gpio_pin_o[0] == $past(gctl_q[GPIO_OUT_LSB]))
      else $error("general pin not driven from register");

   latch_c: cover property (latch);
   swrst_c: cover property (swrst_q && state_q == ST_RUN ##1 state_q == ST_SAMPLE);
   capture_c: cover property (|ts_capture);
   ack_c: cover property (wb_ack_o && wb_we_i);
endmodule

// >>> rscl_pkg.sv
package rscl_pkg;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ         = 40;
   localparam int STRAP_SETTLE_NS = 200;  // pins released before sampling
   // least time: round up to whole cycles
   localparam int SETTLE_CYC      = (STRAP_SETTLE_NS * CLK_MHZ + 999) / 1000;

   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam int          ADR_W         = 4;
   localparam logic [3:0] REG_CTRL      = 4'h0;
   localparam logic [3:0] REG_STRAP     = 4'h4;
   localparam logic [3:0] REG_GPIO_CTRL = 4'h8;
   localparam logic [3:0] REG_GPIO_STAT = 4'hC;
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_WAKE_HI   = 1;
   localparam int CTRL_SWRST_BIT = 2;
   localparam int GPIO_DIR_LSB   = 0;
   localparam int GPIO_OUT_LSB   = 2;
   localparam int GPIO_TRIG_LSB  = 4;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {P3_MII = 2'h0, P3_RMII = 2'h1, P3_RSVD = 2'h2,
                             P3_RGMII = 2'h3} rscl_if_t;
   typedef enum logic [1:0] {MG_MDIO = 2'h0, MG_I2C = 2'h1, MG_SPI = 2'h2} rscl_mgmt_t;
   typedef enum logic [1:0] {PHY_RSVD = 2'h0, PHY_AN_EEE = 2'h1, PHY_100_MDIX = 2'h2,
                             PHY_100_MDI = 2'h3} rscl_phy_t;
   typedef enum logic [1:0] {ST_SAMPLE = 2'b01, ST_RUN = 2'b10} rscl_state_t;

   typedef struct packed {
      logic       test_mode;
      logic [1:0] phy_cfg;
      logic [1:0] mgmt;
      logic [1:0] p3_if;
      logic       p3_speed;
      logic       p3_role;
      logic       iba_n;
      logic       start_sw;
   } rscl_strap_t;
   localparam int          STRAP_W   = 11;
   localparam rscl_strap_t STRAP_RST = 11'h10F;  // all documented defaults

   typedef struct packed {
      logic       fwd_en;
      logic       frame_based_management_en;
      logic       p3_mac_mode;
      logic       p3_refclk_out;
      logic       p3_gig;
      rscl_if_t   p3_if;
      logic       p3_if_bad;
      rscl_mgmt_t mgmt_sel;
      rscl_phy_t  phy_mode;
      logic       phy_bad;
      logic       test_mode;
   } rscl_cfg_t;
endpackage

// >>> rscl_board.sv
// ----------------------------------------------------------------
// board model: strap resistors, pull-ups and pin drivers
// ----------------------------------------------------------------
module rscl_board
   import rscl_pkg::*;
(
   input  wire logic [STRAP_W-1:0] strap,
   input  wire logic [3:0]         ind_o,
   input  wire logic [3:0]         ind_oe,
   input  wire logic               wake_o,
   input  wire logic               wake_oe,
   input  wire logic               irq_o,
   input  wire logic               irq_oe,
   input  wire logic [1:0]         gpio_o,
   input  wire logic [1:0]         gpio_oe,
   input  wire logic [1:0]         gpio_drv,
   output logic      [3:0]         ind_lvl,
   output logic                    wake_lvl,
   output logic                    irq_lvl,
   output logic      [1:0]         gpio_lvl,
   output logic      [3:0]         rx_bits,
   output logic                    rx_err,
   output logic                    rx_val
);
   // a released shared pin settles to its strap resistor, never the last driven value
   always_comb begin
      for (int k = 0; k < 4; k++) begin
         ind_lvl[k] = ind_oe[k] ? ind_o[k] : strap[k];
      end
      wake_lvl = wake_oe ? wake_o : strap[8];
   end

   // open-drain line: only a driven low wins over the pull-up
   assign irq_lvl = (irq_oe === 1'b1 && irq_o === 1'b0) ? 1'b0 : 1'b1;

   // general pins: device drive wins, else the far-side driver
   assign gpio_lvl = (gpio_oe & gpio_o) | (~gpio_oe & gpio_drv);

   // receive pins carry strap levels at all times; no link traffic is modelled
   assign rx_bits = {strap[5], strap[4], strap[7], strap[6]};
   assign rx_err  = strap[9];
   assign rx_val  = strap[10];
endmodule

// >>> reset_strap_config_latch_bench.sv
module reset_strap_config_latch_bench
   import rscl_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic        core_clk = 1'b0;
   logic        resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [3:0]  wb_adr_i, wb_sel_i, ind_lvl, ind_o, ind_oe, rx_bits, led_on;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic        rx_err, rx_val, wake_lvl, wake_o, wake_oe, irq_o, irq_oe, irq_lvl;
   logic        irq_req, energy_detect, pd_exit, strap_busy;
   logic [1:0]  gpio_lvl, gpio_o, gpio_oe, gpio_drv, ptp_trigger, ts_capture;
   rscl_cfg_t   cfg_o;
   logic [10:0] strap;
   logic [10:0] pats [4] = '{11'h10F, 11'h251, 11'h7AA, 11'h0F4};
   int          err_count, checks, cycles, n;

   // clock at 40 MHz
   always #12.5 core_clk = ~core_clk;

   rscl_top #(.SETTLE(4)) u_rscl_top (
      .core_clk(core_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .port1_indicator_a_i(ind_lvl[0]), .port1_indicator_a_o(ind_o[0]),
      .port1_indicator_a_oe(ind_oe[0]), .port1_indicator_b_i(ind_lvl[1]),
      .port1_indicator_b_o(ind_o[1]), .port1_indicator_b_oe(ind_oe[1]),
      .port2_indicator_a_i(ind_lvl[2]), .port2_indicator_a_o(ind_o[2]),
      .port2_indicator_a_oe(ind_oe[2]), .port2_indicator_b_i(ind_lvl[3]),
      .port2_indicator_b_o(ind_o[3]), .port2_indicator_b_oe(ind_oe[3]),
      .port3_rx_bit3(rx_bits[3]), .port3_rx_bit2(rx_bits[2]), .port3_rx_bit1(rx_bits[1]),
      .port3_rx_bit0(rx_bits[0]), .port3_rx_error(rx_err), .port3_rx_valid(rx_val),
      .wake_event_out_i(wake_lvl), .wake_event_out_o(wake_o), .wake_event_out_oe(wake_oe),
      .irq_out_low_o(irq_o), .irq_out_low_oe(irq_oe), .gpio_pin_i(gpio_lvl),
      .gpio_pin_o(gpio_o), .gpio_pin_oe(gpio_oe), .led_on(led_on), .irq_req(irq_req),
      .energy_detect(energy_detect), .pd_exit(pd_exit), .ptp_trigger(ptp_trigger),
      .ts_capture(ts_capture), .cfg_o(cfg_o), .strap_busy(strap_busy));

   rscl_board u_rscl_board (
      .strap(strap), .ind_o(ind_o), .ind_oe(ind_oe), .wake_o(wake_o), .wake_oe(wake_oe),
      .irq_o(irq_o), .irq_oe(irq_oe), .gpio_o(gpio_o), .gpio_oe(gpio_oe),
      .gpio_drv(gpio_drv), .ind_lvl(ind_lvl), .wake_lvl(wake_lvl), .irq_lvl(irq_lvl),
      .gpio_lvl(gpio_lvl), .rx_bits(rx_bits), .rx_err(rx_err), .rx_val(rx_val));

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // classic single cycle; waits for ack with no timeout of its own, only the watchdog ends a hang
   task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat,
                     output logic [31:0] rd);
      @(posedge core_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_sel_i <= 4'hF;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      do @(posedge core_clk); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask

   task automatic wr(input logic [3:0] adr, input logic [31:0] dat);
      logic [31:0] d;
      wb(1'b1, adr, dat, d);
   endtask

   task automatic rdc(input logic [3:0] adr, input logic [31:0] exp);
      logic [31:0] d;
      wb(1'b0, adr, 32'h0, d);
      chk(d, exp);
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge core_clk);
   endtask

   // shared pins must be released while sampling, then latched values show
   task automatic wait_latch;
      do @(posedge core_clk); while (strap_busy !== 1'b1);
      chk({27'h0, ind_oe, wake_oe}, 32'h0);
      do @(posedge core_clk); while (strap_busy !== 1'b0);
      tick(2);
   endtask

   function automatic rscl_cfg_t exp_cfg(input rscl_strap_t s, input logic sb);
      rscl_cfg_t c;
      c.fwd_en                    = s.start_sw | sb;
      c.frame_based_management_en = ~s.iba_n;
      c.p3_mac_mode               = s.p3_role;
      c.p3_refclk_out             = ~s.p3_role & (s.p3_if == 2'h1);
      c.p3_gig                    = ~s.p3_speed;
      c.p3_if                     = (s.p3_if == 2'h2) ? P3_MII : rscl_if_t'(s.p3_if);
      c.p3_if_bad                 = (s.p3_if == 2'h2);
      c.mgmt_sel                  = s.mgmt[1] ? MG_SPI : rscl_mgmt_t'(s.mgmt);
      c.phy_mode = (s.phy_cfg == 2'h0) ? PHY_AN_EEE : rscl_phy_t'(s.phy_cfg);
      c.phy_bad                   = (s.phy_cfg == 2'h0);
      c.test_mode                 = s.test_mode;
      return c;
   endfunction

   task automatic tally_and_finish;
      $display("checks=%0d err_count=%0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // watchdog: the whole run needs well under 2000 cycles
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         tally_and_finish();
      end
   end

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      {resetn, wb_cyc_i, wb_stb_i, wb_we_i, irq_req, energy_detect, pd_exit} = '0;
      {wb_adr_i, wb_dat_i, led_on, gpio_drv, ptp_trigger} = '0;
      wb_sel_i = 4'hF;
      strap = pats[0];
      tick(4);
      resetn <= 1'b1;
      // latch each pattern: reset release, soft reset, power-down exit, soft reset
      for (int i = 0; i < 4; i++) begin
         if (i > 0) begin
            @(posedge core_clk);
            strap <= pats[i];
            if (i == 2) begin
               @(posedge core_clk);
               pd_exit <= 1'b1;
               @(posedge core_clk);
               pd_exit <= 1'b0;
            end else begin
               wr(REG_CTRL, 32'h4);
            end
         end
         wait_latch();
         rdc(REG_STRAP, {21'h0, pats[i]});
         chk(32'(cfg_o), 32'(exp_cfg(pats[i], 1'b0)));
         $display("test strap pattern %0d done", i);
      end
      // pins change between latch events: the settings must not follow
      @(posedge core_clk);
      strap <= ~pats[3];
      tick(3);
      rdc(REG_STRAP, {21'h0, pats[3]});
      wr(REG_CTRL, 32'h1);
      tick(2);
      chk(cfg_o.fwd_en, 1'b1);
      rdc(REG_CTRL, 32'h1);
      rdc(4'h2, 32'h0);
      $display("test hold and start done");
      led_on <= 4'b0101;
      tick(2);
      chk(ind_lvl, 4'b1010);
      chk(ind_oe, 4'hF);
      chk(irq_lvl, 1'b1);
      irq_req <= 1'b1;
      tick(2);
      chk({irq_lvl, irq_oe}, 2'b01);
      irq_req <= 1'b0;
      energy_detect <= 1'b1;
      tick(2);
      chk(wake_lvl, 1'b0);
      wr(REG_CTRL, 32'h3);
      tick(2);
      chk(wake_lvl, 1'b1);
      energy_detect <= 1'b0;
      tick(2);
      chk(wake_lvl, 1'b0);
      $display("test pins done");
      wr(REG_GPIO_CTRL, 32'h05);
      tick(2);
      chk({gpio_oe, gpio_lvl}, 4'b0101);
      wr(REG_GPIO_CTRL, 32'h11);
      tick(2);
      chk(gpio_lvl[0], 1'b0);
      ptp_trigger <= 2'b01;
      tick(2);
      chk(gpio_lvl[0], 1'b1);
      gpio_drv <= 2'b10;
      n = 0;
      repeat (8) begin
         @(posedge core_clk);
         if (ts_capture[1] === 1'b1) n++;
      end
      chk(n, 1);
      rdc(REG_GPIO_STAT, 32'h3);
      $display("test general pins done");
      tally_and_finish();
   end
endmodule
